// ### sspc_pkg.sv
// constants and types for the synchronous sram port control block
`default_nettype none
package sspc_pkg;
	localparam int LANES      = 4;
	localparam int LANE_W     = 8;
	localparam int DATA_W     = LANES * LANE_W;
	localparam int ADDR_W     = 10;
	localparam int DEPTH      = 1 << ADDR_W;
	localparam int BURST_W    = 2;
	localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
	localparam logic [LANES-1:0]  PAR_RST  = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000;
	typedef enum logic [1:0] {
		SSPC_IDLE,
		SSPC_READ,
		SSPC_WRITE
	} sspc_op_e;
endpackage : sspc_pkg
`default_nettype wire

// ### sspc_mem.sv
// word memory with per-lane write strobes and registered read data
`timescale 1ns/1ps
`default_nettype none
module sspc_mem (
	// clock
	input  wire logic                                  mclk,
	// write side
	input  wire logic                                  wr_en,
	input  wire logic [sspc_pkg::LANES-1:0]            wr_lane,
	input  wire logic [sspc_pkg::ADDR_W-1:0]           wr_addr,
	input  wire logic [sspc_pkg::DATA_W+sspc_pkg::LANES-1:0] wr_data,
	// read side
	input  wire logic                                  rd_en,
	input  wire logic [sspc_pkg::ADDR_W-1:0]           rd_addr,
	output logic      [sspc_pkg::DATA_W+sspc_pkg::LANES-1:0] rd_data
);
	localparam int LW = sspc_pkg::LANE_W + 1;
	logic [sspc_pkg::DATA_W+sspc_pkg::LANES-1:0] mem [sspc_pkg::DEPTH];

	// each stored lane holds eight data bits and its parity bit
	always_ff @(posedge mclk)
	begin
		for (int i = 0; i < sspc_pkg::LANES; i++)
			if (wr_en && wr_lane[i])
				mem[wr_addr][i*LW +: LW] <= wr_data[i*LW +: LW];
		if (rd_en)
			rd_data <= mem[rd_addr];
	end
endmodule : sspc_mem
`default_nettype wire

// ### sspc_port.sv
// pin-side control, data capture and read delivery of the sram port
//
// How it works
// - every synchronous input is taken on a rising edge only while clk_gate_n is low.
// - chip_sel_n_first is active low and joins the other two selects to select the device.
// - chip_sel_high is active high and joins the two active-low selects.
// - with output enable high the data and parity pins are released and act as inputs.
// - pins are released in a write data phase and while deselected, except the first cycle after deselecting a read, which drives its data.
// - a high clk_gate_n holds every state except the output enable sync and pin drive, and does not deselect the device.
// - data pins acting as inputs are registered on the rising edge.
// - a read returns the word at the address sampled at the cycle start.
// - each data lane is eight bits wide.
// - each parity lane is one bit and behaves exactly like its data lane.
// - write enable is active low and sampled only while clk_gate_n is low.
// - advance_or_load high steps the burst counter while a read or write is active (not when idle) and low loads a new address.
// - byte_lane_write_n bits are active low and each writes only its own lane and parity.
`timescale 1ns/1ps
`default_nettype none
module sspc_port (
	// clock and reset
	input  wire logic                          mclk,
	input  wire logic                          nrst,
	// synchronous controls
	input  wire logic                          clk_gate_n,
	input  wire logic                          chip_sel_n_first,
	input  wire logic                          chip_sel_high,
	input  wire logic                          chip_sel_n_third,
	input  wire logic                          write_n,
	input  wire logic                          advance_or_load,
	input  wire logic [sspc_pkg::LANES-1:0]    byte_lane_write_n,
	input  wire logic [sspc_pkg::ADDR_W-1:0]   addr,
	// asynchronous output enable
	input  wire logic                          out_en_n,
	// data lanes
	input  wire logic [sspc_pkg::DATA_W-1:0]   data_in,
	output logic      [sspc_pkg::DATA_W-1:0]   data_out,
	output logic      [sspc_pkg::DATA_W-1:0]   data_oe_n,
	// parity lanes
	input  wire logic [sspc_pkg::LANES-1:0]    parity_lane_in,
	output logic      [sspc_pkg::LANES-1:0]    parity_lane_out,
	output logic      [sspc_pkg::LANES-1:0]    parity_lane_oe_n
);
	localparam int LW = sspc_pkg::LANE_W + 1;
	localparam int WW = sspc_pkg::DATA_W + sspc_pkg::LANES;

	// two-stage sync of the asynchronous output enable
	logic out_en_n_s1_q;
	logic out_en_n_q;

	// cycle state
	sspc_pkg::sspc_op_e                op_q,     op_d;
	logic [sspc_pkg::ADDR_W-1:0]       base_q;
	logic [sspc_pkg::BURST_W-1:0]      burst_q;
	logic [sspc_pkg::LANES-1:0]        wlane_q;
	logic [sspc_pkg::ADDR_W-1:0]       acc_q;
	logic [sspc_pkg::DATA_W-1:0]       din_q;
	logic [sspc_pkg::LANES-1:0]        pin_q;
	logic [sspc_pkg::DATA_W-1:0]       dout_q;
	logic [sspc_pkg::LANES-1:0]        pout_q;
	logic                              drive_q;

	// decode
	wire take      = !clk_gate_n;
	wire selected  = !chip_sel_n_first && chip_sel_high
		&& !chip_sel_n_third;
	wire load      = take && !advance_or_load;
	wire advance   = take && advance_or_load && op_q != sspc_pkg::SSPC_IDLE;
	wire new_read  = load && selected && write_n;
	wire new_write = load && selected && !write_n;
	wire [sspc_pkg::ADDR_W-1:0] step_addr =
		base_q + sspc_pkg::ADDR_W'(burst_q + 2'h1);
	wire [sspc_pkg::ADDR_W-1:0] cyc_addr = load ? addr : step_addr;
	wire cyc_read  = new_read || (advance && op_q == sspc_pkg::SSPC_READ);
	wire cyc_write = new_write || (advance && op_q == sspc_pkg::SSPC_WRITE);
	wire phase_wr  = op_q == sspc_pkg::SSPC_WRITE && take;
	wire pins_in   = !drive_q;

	always_comb
	begin
		op_d = op_q;
		if (load)
			op_d = new_read  ? sspc_pkg::SSPC_READ :
			       new_write ? sspc_pkg::SSPC_WRITE : sspc_pkg::SSPC_IDLE;
	end

	// memory write pairs each data byte with its parity bit
	logic [WW-1:0] wr_word;
	logic [WW-1:0] rd_word;
	always_comb
	begin
		for (int i = 0; i < sspc_pkg::LANES; i++)
			wr_word[i*LW +: LW] = {parity_lane_in[i],
				data_in[i*sspc_pkg::LANE_W +: sspc_pkg::LANE_W]};
	end

	sspc_mem u_mem (
		.mclk    (mclk),
		.wr_en   (phase_wr),
		.wr_lane (wlane_q),
		.wr_addr (acc_q),
		.wr_data (wr_word),
		.rd_en   (take && cyc_read),
		.rd_addr (cyc_addr),
		.rd_data (rd_word)
	);

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			out_en_n_s1_q <= 1'b1;
			out_en_n_q    <= 1'b1;
		end
		else
		begin
			out_en_n_s1_q <= out_en_n;
			out_en_n_q    <= out_en_n_s1_q;
		end
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			op_q        <= sspc_pkg::SSPC_IDLE;
			base_q      <= sspc_pkg::ADDR_RST;
			burst_q     <= '0;
			wlane_q     <= '0;
			acc_q       <= sspc_pkg::ADDR_RST;
		end
		else if (take)
		begin
			op_q        <= op_d;
			acc_q       <= cyc_addr;
			if (load)
			begin
				base_q  <= addr;
				burst_q <= '0;
			end
			else if (advance)
				burst_q <= burst_q + 2'h1;
			if (cyc_write)
				wlane_q <= ~byte_lane_write_n;
			else
				wlane_q <= '0;
		end
	end

	// input data register
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			din_q <= sspc_pkg::DATA_RST;
			pin_q <= sspc_pkg::PAR_RST;
		end
		else if (take && pins_in)
		begin
			din_q <= data_in;
			pin_q <= parity_lane_in;
		end
	end

	// read data and driver enable
	logic [sspc_pkg::DATA_W-1:0] rd_data_w;
	logic [sspc_pkg::LANES-1:0]  rd_par_w;
	always_comb
	begin
		for (int i = 0; i < sspc_pkg::LANES; i++)
		begin
			rd_data_w[i*sspc_pkg::LANE_W +: sspc_pkg::LANE_W] =
				rd_word[i*LW +: sspc_pkg::LANE_W];
			rd_par_w[i] = rd_word[i*LW + sspc_pkg::LANE_W];
		end
	end

	// drive follows the op of the cycle before, so the first cycle after
	// deselect still drives the pending read data; a write right after a read
	// gives it up so the host owns the bus in the write data phase
	wire drive_d = !out_en_n_q && op_q == sspc_pkg::SSPC_READ
		&& !new_write;

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			dout_q  <= sspc_pkg::DATA_RST;
			pout_q  <= sspc_pkg::PAR_RST;
			drive_q <= 1'b0;
		end
		else
		begin
			drive_q <= drive_d;
			if (take && op_q == sspc_pkg::SSPC_READ)
			begin
				dout_q <= rd_data_w;
				pout_q <= rd_par_w;
			end
		end
	end

	assign data_out         = dout_q;
	assign parity_lane_out  = pout_q;
	assign data_oe_n        = {sspc_pkg::DATA_W{!drive_q}};
	assign parity_lane_oe_n = {sspc_pkg::LANES{!drive_q}};

	chk_hold_when_gated: assert property (@(posedge mclk) disable iff (!nrst)
		clk_gate_n |=> $stable(op_q) && $stable(burst_q))
		else $error("state moved while clock gated");
	chk_release_oe_high: assert property (@(posedge mclk) disable iff (!nrst)
		out_en_n_q |=> data_oe_n[0])
		else $error("pins driven with output enable high");
	chk_no_drive_write: assert property (@(posedge mclk) disable iff (!nrst)
		op_q != sspc_pkg::SSPC_READ |=> data_oe_n[0])
		else $error("pins driven outside a read");
	chk_write_release: assert property (@(posedge mclk) disable iff (!nrst)
		new_write |=> data_oe_n[0])
		else $error("pins driven in a write data phase");
	chk_select_read_op: assert property (@(posedge mclk) disable iff (!nrst)
		new_read |=> op_q == sspc_pkg::SSPC_READ)
		else $error("selected read not started");
	chk_deselect_idle: assert property (@(posedge mclk) disable iff (!nrst)
		load && !chip_sel_high |=> op_q == sspc_pkg::SSPC_IDLE)
		else $error("deselect did not idle");
	chk_burst_step: assert property (@(posedge mclk) disable iff (!nrst)
		advance |=> burst_q == $past(burst_q) + 2'h1)
		else $error("burst counter did not step");
	chk_write_lanes: assert property (@(posedge mclk) disable iff (!nrst)
		new_write |=> wlane_q == ~$past(byte_lane_write_n))
		else $error("write lanes wrong");
	chk_capture_in: assert property (@(posedge mclk) disable iff (!nrst)
		take && pins_in |=> din_q == $past(data_in)
		&& pin_q == $past(parity_lane_in))
		else $error("input data not captured");
	chk_oe_parity_same: assert property (@(posedge mclk) disable iff (!nrst)
		parity_lane_oe_n[0] == data_oe_n[0])
		else $error("parity enable differs from data");
	chk_write_gated: assert property (@(posedge mclk) disable iff (!nrst)
		clk_gate_n && op_q == sspc_pkg::SSPC_IDLE |=> op_q == sspc_pkg::SSPC_IDLE)
		else $error("write taken while gated");
endmodule : sspc_port
`default_nettype wire

// ### sspc_host_model.sv
// host-side model of the shared data and parity wires
`timescale 1ns/1ps
`default_nettype none
module sspc_host_model (
	// clock
	input  wire logic                  mclk,
	// device side
	input  wire logic [35:0]           dev_q,
	input  wire logic [35:0]           dev_oe_n,
	// host side
	input  wire logic [35:0]           host_d,
	input  wire logic                  host_drv,
	// resolved wire
	output logic      [35:0]           wire_v
);
	logic [35:0] last_q;
	initial last_q = '0;
	// released bits with no driver show the inverse of their last level
	always_comb
		for (int i = 0; i < 36; i++)
			wire_v[i] = !dev_oe_n[i] ? dev_q[i] : host_drv ? host_d[i] : ~last_q[i];
	always @(posedge mclk)
		last_q <= wire_v;
endmodule : sspc_host_model
`default_nettype wire

// ### sspc_port_tb.sv
// self-checking bench for the sram port control block
`timescale 1ns/1ps
`default_nettype none
module sspc_port_tb;
	localparam int W = sspc_pkg::DATA_W + sspc_pkg::LANES;
	logic                        mclk, nrst, cg_n, wn, adv, oe_in_n, hdrv;
	logic [2:0]                  sel;
	logic [sspc_pkg::LANES-1:0]  bw_n, par_o, par_oe_n;
	logic [sspc_pkg::ADDR_W-1:0] a;
	logic [sspc_pkg::DATA_W-1:0] d_o, d_oe_n;
	logic [W-1:0]                wire_v, hd;
	logic [W-1:0]                mem_m [int];
	int                          n_errors, compares;
	sspc_port dut (.mclk(mclk), .nrst(nrst), .clk_gate_n(cg_n),
		.chip_sel_n_first(!sel[0]), .chip_sel_high(sel[1]), .chip_sel_n_third(!sel[2]),
		.write_n(wn), .advance_or_load(adv), .byte_lane_write_n(bw_n), .addr(a),
		.out_en_n(oe_in_n), .data_in(wire_v[31:0]), .data_out(d_o), .data_oe_n(d_oe_n),
		.parity_lane_in(wire_v[35:32]), .parity_lane_out(par_o),
		.parity_lane_oe_n(par_oe_n));
	sspc_host_model host (.mclk(mclk), .dev_q({par_o, d_o}),
		.dev_oe_n({par_oe_n, d_oe_n}), .host_d(hd), .host_drv(hdrv), .wire_v(wire_v));
	task automatic give_verdict;
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict
	task automatic chk_word(input logic [W-1:0] e, input logic [W-1:0] g);
		compares++;
		if (g !== e)
		begin
			n_errors++;
			$display("BAD %0t word %h expected %h", $time, g, e);
		end
	endtask : chk_word
	task automatic chk_oe(input logic e);
		compares++;
		if ({par_oe_n, d_oe_n} !== {W{e}})
		begin
			n_errors++;
			$display("BAD %0t drive enables %h", $time, {par_oe_n, d_oe_n});
		end
	endtask : chk_oe
	task automatic cyc(input logic g, input logic [2:0] s, input logic w, input logic ad);
		cg_n = g;
		sel = s;
		wn = w;
		adv = ad;
		@(posedge mclk);
		#1;
	endtask : cyc
	task automatic wr(input int ad, input logic [W-1:0] dv, input logic [3:0] b,
		input logic [2:0] s);
		logic [W-1:0] m;
		a = ad[9:0];
		bw_n = b;
		hd = dv;
		cyc(0, s, 0, 0);
		hdrv = 1;
		cyc(0, 3'h0, 1, 0);
		chk_oe(1);
		hdrv = 0;
		m = mem_m.exists(ad) ? mem_m[ad] : 'x;
		for (int i = 0; i < 4; i++)
			if (!b[i] && s == 3'h7)
			begin
				m[8*i+:8] = dv[8*i+:8];
				m[32+i] = dv[32+i];
			end
		mem_m[ad] = m;
	endtask : wr
	task automatic rd(input int ad);
		a = ad[9:0];
		cyc(0, 3'h7, 1, 0);
		cyc(0, 3'h0, 1, 0);
		chk_word(mem_m[ad], {par_o, d_o});
	endtask : rd
	initial
	begin
		mclk = 0;
		forever #2 mclk = ~mclk;
	end
	initial
	begin
		#80000;
		n_errors++;
		give_verdict();
	end
	initial
	begin
		int ads [8];
		int base;
		{nrst, cg_n, sel, wn, adv, oe_in_n, hdrv, bw_n, a, hd} = '0;
		{cg_n, wn, oe_in_n, bw_n} = '1;
		void'($urandom(32'h6c48));
		repeat (6) @(posedge mclk);
		#1 nrst = 1;
		chk_oe(1);
		for (int k = 0; k < 8; k++)
		begin
			ads[k] = 4 * k + $urandom % 4;
			wr(ads[k], W'({$urandom, $urandom}), 4'h0, 3'h7);
			wr(ads[k], W'({$urandom, $urandom}), 4'($urandom), 3'h7);
		end
		foreach (ads[k])
			rd(ads[k]);
		$display("test lane writes done");
		for (int j = 0; j < 3; j++)
		begin
			wr(ads[0], W'({$urandom, $urandom}), 4'h0, 3'h7 ^ (3'h1 << j));
			rd(ads[0]);
		end
		$display("test selects done");
		base = 64 + 4 * ($urandom % 32);
		for (int j = 0; j < 4; j++)
			wr(base + j, W'({$urandom, $urandom}), 4'h0, 3'h7);
		a = base[9:0];
		cyc(0, 3'h7, 1, 0);
		for (int j = 0; j < 4; j++)
		begin
			cyc(0, j < 3 ? 3'h7 : 3'h0, 1, j < 3);
			chk_word(mem_m[base + j], {par_o, d_o});
		end
		$display("test burst done");
		rd(ads[1]);
		a = ads[0][9:0];
		hd = W'({$urandom, $urandom});
		hdrv = 1;
		for (int j = 0; j < 4; j++)
		begin
			cyc(1, 3'h7, j[0], 0);
			chk_word(mem_m[ads[1]], {par_o, d_o});
		end
		hdrv = 0;
		rd(ads[0]);
		$display("test clock gate done");
		oe_in_n = 0;
		repeat (6) cyc(0, 3'h7, 1, 0);
		chk_oe(0);
		chk_word(mem_m[ads[0]], wire_v);
		oe_in_n = 1;
		repeat (5) cyc(0, 3'h7, 1, 0);
		chk_oe(1);
		oe_in_n = 0;
		repeat (4) cyc(0, 3'h7, 1, 0);
		repeat (2) cyc(0, 3'h0, 1, 0);
		chk_oe(1);
		cyc(0, 3'h7, 1, 0);
		chk_oe(1);
		cyc(0, 3'h0, 1, 0);
		chk_oe(0);
		chk_word(mem_m[ads[0]], wire_v);
		cyc(0, 3'h7, 1, 0);
		wr(ads[2], W'({$urandom, $urandom}), 4'h0, 3'h7);
		rd(ads[2]);
		oe_in_n = 1;
		$display("test output enable done");
		give_verdict();
	end
endmodule : sspc_port_tb
`default_nettype wire
